/* File: logic/pcts_pkg.sv */
package pcts_pkg;
  // ==========================================================
  // widths and channel count
  localparam int NCH = 6;
  localparam int DW  = 8;
  localparam int AW  = 5;
  // ==========================================================
  // register map (byte index on the plain port)
  localparam logic [4:0] ADDR_CNT0   = 5'h00;  // counters 0..5 at 0x00..0x05
  localparam logic [4:0] ADDR_PER0   = 5'h08;  // periods 0..5 at 0x08..0x0D
  localparam logic [4:0] ADDR_DTY0   = 5'h10;  // duties 0..5 at 0x10..0x15
  localparam logic [4:0] ADDR_RUN    = 5'h18;  // channel run bits
  localparam logic [4:0] ADDR_CAE    = 5'h19;  // center align select
  localparam logic [4:0] ADDR_POL    = 5'h1A;  // start level select
  localparam logic [4:0] ADDR_CAT    = 5'h1B;  // bit0: concatenate 4 and 5
  localparam logic [4:0] ADDR_SDN    = 5'h1C;  // emergency shutdown control
  localparam logic [4:0] ADDR_SCTA   = 5'h1D;  // scale counter test a
  localparam logic [4:0] ADDR_SCTB   = 5'h1E;  // scale counter test b
  // ==========================================================
  // shutdown register fields
  localparam int SDN_FLAG  = 7;
  localparam int SDN_IE    = 6;
  localparam int SDN_RSTRT = 5;
  localparam int SDN_LVL   = 4;
  localparam int SDN_PIN   = 2;
  localparam int SDN_INL   = 1;
  localparam int SDN_ENA   = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

/* File: logic/pcts_timer.sv */
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
module pcts_timer
  import pcts_pkg::*;
(
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      clk_en_i,
  // register port
  input  wire logic [pcts_pkg::AW-1:0]   addr_i,
  input  wire logic [pcts_pkg::DW-1:0]   wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [pcts_pkg::DW-1:0]   rdata_o,
  // channel clock ticks, one per channel
  input  wire logic [pcts_pkg::NCH-1:0]  tick_i,
  // channel 5 shutdown pin
  input  wire logic                      ch5_pin_i,
  output logic                           ch5_oe_o,
  // outputs
  output logic      [pcts_pkg::NCH-1:0]  pwm_o,
  output logic                           irq_o
);
  import pcts_pkg::*;

  // ==========================================================
  // register state
  logic [DW-1:0]  cnt_r  [NCH];
  logic [DW-1:0]  perb_r [NCH];
  logic [DW-1:0]  pera_r [NCH];
  logic [DW-1:0]  dtyb_r [NCH];
  logic [DW-1:0]  dtya_r [NCH];
  logic [NCH-1:0] down_r;
  logic [NCH-1:0] out_r;
  logic [NCH-1:0] run_r;
  logic [NCH-1:0] cae_r;
  logic [NCH-1:0] pol_r;
  logic           cat_r;
  logic           flag_r;
  logic           ie_r;
  logic           lvl_r;
  logic           inl_r;
  logic           ena_r;
  logic           hold_r;
  logic [2:0]     pin_sync_r;
  logic           pin_last_r;

  // ==========================================================
  // decode helpers
  function automatic logic in_group(input logic [AW-1:0] a, input logic [AW-1:0] base);
    in_group = (a >= base) && (a < base + 5'(NCH));
  endfunction

  function automatic logic [2:0] group_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
    logic [AW-1:0] d;
    d = a - base;
    group_idx = d[2:0];
  endfunction

  // ==========================================================
  // pin synchroniser, change counts when stages two and three agree
  logic pin_lvl;
  logic pin_act;
  logic pin_evt;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync_r <= 3'h0;
    end else if (clk_en_i) begin
      pin_sync_r <= {pin_sync_r[1:0], ch5_pin_i};
    end
  end
  // stable level once stages two and three agree
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_last_r <= 1'b0;
    end else if (clk_en_i && (pin_sync_r[1] == pin_sync_r[2])) begin
      pin_last_r <= pin_sync_r[2];
    end
  end
  assign pin_lvl = pin_last_r;
  assign pin_act = ena_r && (pin_lvl == inl_r);
  assign pin_evt = clk_en_i && ena_r && (pin_sync_r[1] == pin_sync_r[2]) && (pin_sync_r[2] != pin_last_r);

  // ==========================================================
  // write decode
  logic       wr_cnt;
  logic       wr_per;
  logic       wr_dty;
  logic [2:0] widx;
  logic       wr_sdn;
  assign wr_cnt = wr_i && in_group(addr_i, ADDR_CNT0);
  assign wr_per = wr_i && in_group(addr_i, ADDR_PER0);
  assign wr_dty = wr_i && in_group(addr_i, ADDR_DTY0);
  assign wr_sdn = wr_i && (addr_i == ADDR_SDN);
  assign widx   = wr_cnt ? group_idx(addr_i, ADDR_CNT0) :
                  wr_per ? group_idx(addr_i, ADDR_PER0) : group_idx(addr_i, ADDR_DTY0);

  // ==========================================================
  // control registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_r <= '0;
      cae_r <= '0;
      pol_r <= '0;
      cat_r <= 1'b0;
    end else if (clk_en_i && wr_i) begin
      if (addr_i == ADDR_RUN) run_r <= wdata_i[NCH-1:0];
      if (addr_i == ADDR_CAE) cae_r <= wdata_i[NCH-1:0];
      if (addr_i == ADDR_POL) pol_r <= wdata_i[NCH-1:0];
      if (addr_i == ADDR_CAT) cat_r <= wdata_i[0];
    end
  end

  // ==========================================================
  // shutdown control register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ie_r  <= 1'b0;
      lvl_r <= 1'b0;
      inl_r <= 1'b0;
      ena_r <= 1'b0;
    end else if (clk_en_i && wr_sdn) begin
      ie_r  <= wdata_i[SDN_IE];
      lvl_r <= wdata_i[SDN_LVL];
      inl_r <= wdata_i[SDN_INL];
      ena_r <= wdata_i[SDN_ENA];
    end
  end

  // change flag: set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (pin_evt) begin
        flag_r <= 1'b1;
      end else if (wr_sdn && wdata_i[SDN_FLAG]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // shutdown hold: set while active, released at counter zero after restart
  logic [NCH-1:0] at_zero;
  logic           restart_ok;
  logic           enable_drop;
  assign restart_ok  = wr_sdn && wdata_i[SDN_RSTRT] && !pin_act;
  // with the enable low a held shutdown is released at the next zero, as after a restart
  assign enable_drop = !ena_r;
  logic           rel_pend_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r     <= 1'b0;
      rel_pend_r <= 1'b0;
    end else if (clk_en_i) begin
      if (pin_act) begin
        hold_r     <= 1'b1;
        rel_pend_r <= 1'b0;
      end else if (rel_pend_r && |(at_zero & run_r)) begin
        hold_r     <= 1'b0;
        rel_pend_r <= 1'b0;
      end else if (hold_r && (restart_ok || enable_drop)) begin
        rel_pend_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // channel counters, buffers and outputs
  logic [15:0] cat_cnt;
  logic [15:0] cat_per;
  logic [15:0] cat_dty;
  logic        cat_end;
  logic        cat_top;
  assign cat_cnt = {cnt_r[4], cnt_r[5]};
  assign cat_per = {pera_r[4], pera_r[5]};
  assign cat_dty = {dtya_r[4], dtya_r[5]};
  assign cat_top = cae_r[5] ? (cat_cnt >= cat_per) : (cat_cnt + 16'h0001 >= cat_per);
  assign cat_end = cae_r[5] ? (((down_r[5] || cat_per == 16'h0001) && cat_cnt == 16'h0001) || cat_per == 16'h0000)
                            : cat_top;

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic       in_cat;
      logic       lead;
      logic       step;
      logic       cwr;
      logic       pend;
      logic       match;
      logic       top;
      assign in_cat = cat_r && (c == 4 || c == 5);
      assign lead   = in_cat ? run_r[5] : run_r[c];
      assign step   = clk_en_i && lead && (in_cat ? tick_i[5] : tick_i[c]);
      // counter write, either byte resets the joined pair
      assign cwr    = wr_cnt && ((widx == 3'(c)) || (in_cat && (widx == 3'd4 || widx == 3'd5)));
      assign top    = cae_r[c] ? (cnt_r[c] >= pera_r[c]) : (cnt_r[c] + 8'h01 >= pera_r[c]);
      // period completes: left at period-1, center when back at 1 on the way down
      assign pend   = in_cat ? cat_end :
                      cae_r[c] ? (((down_r[c] || pera_r[c] == 8'h01) && cnt_r[c] == 8'h01)
                                  || pera_r[c] == 8'h00) : top;
      // duty reached: from the match on while counting up, above it on the way down
      assign match  = in_cat ? (down_r[5] ? (cat_cnt > cat_dty) : (cat_cnt >= cat_dty))
                             : (down_r[c] ? (cnt_r[c] > dtya_r[c]) : (cnt_r[c] >= dtya_r[c]));
      assign at_zero[c] = (cnt_r[c] == 8'h00);

      // buffers always take the written value, reads return them
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          perb_r[c] <= RST_BYTE;
          dtyb_r[c] <= RST_BYTE;
        end else if (clk_en_i) begin
          if (wr_per && widx == 3'(c)) perb_r[c] <= wdata_i;
          if (wr_dty && widx == 3'(c)) dtyb_r[c] <= wdata_i;
        end
      end

      // active latches load on period end, counter write or while disabled
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pera_r[c] <= RST_BYTE;
          dtya_r[c] <= RST_BYTE;
        end else if (clk_en_i) begin
          if (!lead) begin
            pera_r[c] <= (wr_per && widx == 3'(c)) ? wdata_i : perb_r[c];
            dtya_r[c] <= (wr_dty && widx == 3'(c)) ? wdata_i : dtyb_r[c];
          end else if (cwr || (step && pend)) begin
            pera_r[c] <= perb_r[c];
            dtya_r[c] <= dtyb_r[c];
          end
        end
      end

      // counter and direction
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cnt_r[c]  <= RST_BYTE;
          down_r[c] <= 1'b0;
        end else if (clk_en_i) begin
          if (cwr) begin
            cnt_r[c]  <= RST_BYTE;
            down_r[c] <= 1'b0;
          end else if (step) begin
            if (pend) begin
              cnt_r[c]  <= RST_BYTE;
              down_r[c] <= 1'b0;
            end else if (in_cat) begin
              // joined pair steps as one 16-bit value
              if (c == 5) cnt_r[c] <= down_r[5] ? 8'(cat_cnt - 16'h0001) : 8'(cat_cnt + 16'h0001);
              else cnt_r[c] <= down_r[5] ? 8'((cat_cnt - 16'h0001) >> 8) : 8'((cat_cnt + 16'h0001) >> 8);
              if (cae_r[5] && cat_top) down_r[c] <= 1'b1;
            end else if (cae_r[c] && (down_r[c] || top)) begin
              cnt_r[c]  <= cnt_r[c] - 8'h01;
              down_r[c] <= 1'b1;
            end else begin
              cnt_r[c]  <= cnt_r[c] + 8'h01;
            end
          end  // holds while not running
        end
      end

      // waveform flip-flop, forced level wins while shut down if the channel's run bit is set
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          out_r[c] <= 1'b0;
        end else if (clk_en_i) begin
          // level follows the count, so each match toggles it once in either direction
          if ((pin_act || hold_r) && run_r[c]) begin
            out_r[c] <= lvl_r;
          end else if (!lead) begin
            out_r[c] <= pol_r[in_cat ? 5 : c];
          end else begin
            out_r[c] <= pol_r[in_cat ? 5 : c] ^ match;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_o    <= '0;
      irq_o    <= 1'b0;
      ch5_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      pwm_o    <= cat_r ? {out_r[5], 1'b0, out_r[3:0]} : out_r;
      irq_o    <= flag_r && ie_r;
      ch5_oe_o <= !ena_r && run_r[5];
    end
  end

  // ==========================================================
  // read mux, data one cycle after the strobe, no side effects
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = RST_BYTE;
    if (in_group(addr_i, ADDR_CNT0)) rd_mux = cnt_r[group_idx(addr_i, ADDR_CNT0)];
    else if (in_group(addr_i, ADDR_PER0)) rd_mux = perb_r[group_idx(addr_i, ADDR_PER0)];
    else if (in_group(addr_i, ADDR_DTY0)) rd_mux = dtyb_r[group_idx(addr_i, ADDR_DTY0)];
    else if (addr_i == ADDR_RUN) rd_mux = {2'b00, run_r};
    else if (addr_i == ADDR_CAE) rd_mux = {2'b00, cae_r};
    else if (addr_i == ADDR_POL) rd_mux = {2'b00, pol_r};
    else if (addr_i == ADDR_CAT) rd_mux = {7'h00, cat_r};
    else if (addr_i == ADDR_SDN) rd_mux = {flag_r, ie_r, 1'b0, lvl_r, 1'b0, pin_lvl, inl_r, ena_r};
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= RST_BYTE;
    end else if (clk_en_i) begin
      rdata_o <= rd_i ? rd_mux : RST_BYTE;
    end
  end

  // ==========================================================
  // assertions
  flag_sets_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pin_evt |=> flag_r) else $error("change flag not set");
  irq_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    clk_en_i |=> irq_o == $past(flag_r && ie_r)) else $error("irq mismatch");
  cnt_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && wr_cnt && widx == 3'd0) |=> cnt_r[0] == 8'h00 && !down_r[0]) else $error("counter not cleared");
  cnt_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!run_r[0] && !cat_r && !wr_cnt) |=> $stable(cnt_r[0])) else $error("counter moved");
  rstrt_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    clk_en_i && rd_i && addr_i == ADDR_SDN |=> !rdata_o[SDN_RSTRT]) else $error("restart bit read one");
  force_lvl_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && pin_act && run_r[0]) |=> out_r[0] == $past(lvl_r)) else $error("not forced");
  left_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && !cat_r && !cae_r[0] && run_r[0] && tick_i[0] && !wr_cnt && pera_r[0] != 8'h00
     && cnt_r[0] + 8'h01 == pera_r[0]) |=> cnt_r[0] == 8'h00) else $error("no wrap");
  dis_load_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && !run_r[1] && wr_per && widx == 3'd1) |=> pera_r[1] == $past(wdata_i)) else $error("no direct load");
  pin_stat_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    clk_en_i && rd_i && addr_i == ADDR_SDN |=> rdata_o[SDN_PIN] == $past(pin_lvl)) else $error("pin status wrong");
  duty_low_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && run_r[0] && !cat_r && !pin_act && !hold_r && !cae_r[0] && cnt_r[0] < dtya_r[0])
    |=> out_r[0] == $past(pol_r[0])) else $error("start level lost");
  center_turn_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && !cat_r && cae_r[1] && run_r[1] && tick_i[1] && !wr_cnt && !down_r[1]
     && cnt_r[1] == pera_r[1] && pera_r[1] > 8'h01) |=> down_r[1] && cnt_r[1] == $past(cnt_r[1]) - 8'h01)
    else $error("no turn at top");
  flag_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) pin_evt ##1 flag_r);
  center_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) cae_r[1] && down_r[1] && cnt_r[1] == 8'h01);
  release_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) hold_r ##1 !hold_r);
  cat_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) cat_r && run_r[5] && cnt_r[5] == 8'hFF);
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import pcts_pkg::*;
  // ==========================================================
  // signals
  logic                 clock_i;
  logic                 rst_n_i;
  logic                 clk_en_i;
  logic [AW-1:0]        addr_i;
  logic [DW-1:0]        wdata_i;
  logic                 wr_i;
  logic                 rd_i;
  logic [DW-1:0]        rdata_o;
  logic [NCH-1:0]       tick_i;
  logic                 ch5_pin_i;
  logic                 ch5_oe_o;
  logic [NCH-1:0]       pwm_o;
  logic                 irq_o;
  logic [7:0]           exp_q[$];
  logic                 rd_seen;
  int                   err_total;
  int                   samples_checked;
  logic [7:0]           per_v;
  logic [7:0]           dty_v;
  logic [7:0]           ctr_tbl[8];
  // ==========================================================
  // device under test
  pcts_timer i_pcts_timer (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rdata_o   (rdata_o),
    .tick_i    (tick_i),
    .ch5_pin_i (ch5_pin_i),
    .ch5_oe_o  (ch5_oe_o),
    .pwm_o     (pwm_o),
    .irq_o     (irq_o)
  );
  // clock at 200 MHz
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // ==========================================================
  // compare, verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // read data stands one cycle after the strobe; take the oldest note
  always @(posedge clock_i) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(rdata_o, 8'hEE);
      end else begin
        check(rdata_o, exp_q.pop_front());
      end
    end
    rd_seen <= rd_i;
  end
  // ==========================================================
  // bus and tick drivers
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock_i);
      tick_i <= 6'h3F;
    end
    @(posedge clock_i);
    tick_i <= 6'h00;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic pin(input logic v);
    @(posedge clock_i);
    ch5_pin_i <= v;
    repeat (8) @(posedge clock_i);
  endtask
  // watchdog
  initial begin
    #(5ns * 30000);
    err_total++;
    close_out();
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_n_i = 1'b0; clk_en_i = 1'b1; addr_i = '0; wdata_i = '0;
    wr_i = 1'b0; rd_i = 1'b0; tick_i = '0; ch5_pin_i = 1'b0; rd_seen = 1'b0;
    err_total = 0; samples_checked = 0;
    ctr_tbl = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h03, 8'h02, 8'h01};
    void'($urandom(32'h7d55));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // period and duty read back what was written, test regs read 0
    for (int c = 0; c < NCH; c++) begin
      per_v = 8'($urandom);
      dty_v = 8'($urandom);
      wr(ADDR_PER0 + 5'(c), per_v);
      wr(ADDR_DTY0 + 5'(c), dty_v);
      rd(ADDR_PER0 + 5'(c), per_v);
      rd(ADDR_DTY0 + 5'(c), dty_v);
    end
    rd(ADDR_SCTA, 8'h00);
    rd(ADDR_SCTB, 8'h00);
    rd(5'h07, 8'h00);
    // left aligned ch0 period 5 duty 2 polarity 1, center ch1 period 4
    wr(ADDR_PER0, 8'h05);
    wr(ADDR_DTY0, 8'h02);
    wr(ADDR_PER0 + 5'd1, 8'h04);
    wr(ADDR_POL, 8'h01);
    wr(ADDR_CAE, 8'h02);
    wr(ADDR_RUN, 8'h03);
    for (int n = 0; n < 12; n++) begin
      wr(ADDR_CNT0, 8'($urandom));
      wr(ADDR_CNT0 + 5'd1, 8'h00);
      ticks(n);
      rd(ADDR_CNT0, 8'(n % 5));
      rd(ADDR_CNT0, 8'(n % 5));
      check({7'h00, pwm_o[0]}, {7'h00, (n % 5) < 2});
      rd(ADDR_CNT0 + 5'd1, ctr_tbl[n % 8]);
    end
    // new period waits for the end of the running period
    wr(ADDR_CNT0, 8'h00);
    wr(ADDR_PER0, 8'h07);
    ticks(11);
    rd(ADDR_CNT0, 8'h06);
    rd(ADDR_PER0, 8'h07);
    // run bit low holds the count, resume continues
    wr(ADDR_CNT0, 8'h00);
    ticks(3);
    wr(ADDR_RUN, 8'h02);
    ticks(4);
    rd(ADDR_CNT0, 8'h03);
    wr(ADDR_RUN, 8'h03);
    ticks(1);
    rd(ADDR_CNT0, 8'h04);
    // duty written while disabled takes effect at once
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_CNT0, 8'h00);
    wr(ADDR_DTY0, 8'h04);
    wr(ADDR_RUN, 8'h01);
    ticks(3);
    check({7'h00, pwm_o[0]}, 8'h01);
    // concatenated 4 and 5, period 0x0100
    wr(ADDR_CAT, 8'h01);
    wr(ADDR_PER0 + 5'd4, 8'h01);
    wr(ADDR_PER0 + 5'd5, 8'h00);
    wr(ADDR_RUN, 8'h21);
    wr(ADDR_CNT0 + 5'd5, 8'h00);
    ticks(300);
    rd(ADDR_CNT0 + 5'd4, 8'h00);
    rd(ADDR_CNT0 + 5'd5, 8'h2C);
    check({7'h00, ch5_oe_o}, 8'h01);
    wr(ADDR_CNT0 + 5'd4, 8'h5A);
    rd(ADDR_CNT0 + 5'd4, 8'h00);
    rd(ADDR_CNT0 + 5'd5, 8'h00);
    wr(ADDR_CAT, 8'h00);
    // emergency shutdown, active high, both forced levels
    for (int l = 0; l < 2; l++) begin
      wr(ADDR_SDN, 8'hC3 | 8'(l << SDN_LVL));
      repeat (2) @(posedge clock_i);
      check({7'h00, ch5_oe_o}, 8'h00);
      pin(1'b1);
      check({7'h00, pwm_o[0]}, 8'(l));
      check({7'h00, irq_o}, 8'h01);
      wr(ADDR_SDN, 8'h63 | 8'(l << SDN_LVL));
      rd(ADDR_SDN, 8'hC7 | 8'(l << SDN_LVL));
      wr(ADDR_SDN, 8'hC3 | 8'(l << SDN_LVL));
      rd(ADDR_SDN, 8'h47 | 8'(l << SDN_LVL));
      check({7'h00, irq_o}, 8'h00);
      pin(1'b0);
      rd(ADDR_SDN, 8'hC3 | 8'(l << SDN_LVL));
      wr(ADDR_SDN, 8'h83 | 8'(l << SDN_LVL));
      pin(1'b1);
      check({7'h00, irq_o}, 8'h00);
      pin(1'b0);
      wr(ADDR_SDN, 8'hA3 | 8'(l << SDN_LVL));
      rd(ADDR_SDN, 8'h03 | 8'(l << SDN_LVL));
    end
    // active level low, forced level 0: a low pin shuts down, a high one is passive
    wr(ADDR_SDN, 8'h81);
    repeat (3) @(posedge clock_i);
    check({7'h00, pwm_o[0]}, 8'h00);
    pin(1'b1);
    wr(ADDR_SDN, 8'hA1);
    wr(ADDR_CNT0, 8'h00);
    ticks(1);
    check({7'h00, pwm_o[0]}, 8'h01);
    pin(1'b0);
    check({7'h00, pwm_o[0]}, 8'h00);
    wr(ADDR_SDN, 8'h80);
    ticks(6);
    check({7'h00, pwm_o[0]}, 8'h01);
    repeat (4) @(posedge clock_i);
    check(8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule
